// File: trc_defs.vh
// constants for the touch report and compensation block
// Function
// - strongest mode reports only the strongest touched button on level output and status.
// - later weaker touches ignored; later stronger touch replaces the reported button.
// - on takeover, level output switches at once or after one idle scan.
// - releasing a weaker unreported button leaves the level output unchanged.
// - after all buttons are released the level output returns to idle level.
// - setting selects ground, supply or idle level while buzzer is active.
// - after buzzer ends, hold idle one scan or go straight to button level.
// - sleep operation drives the level output to ground.
// - each period measure enabled inputs one by one, store counts, skip disabled.
// - after the last enabled input the front end shuts down until next period.
// - accumulation cycles per measurement are set per input.
// - a 16-bit compensation value per input drives the untouched count toward zero.
// - at power-up search compensation values giving zero counts, store and apply them.
// - compensation values are lost at shutdown and derived again at power-up.
// - averaged count beyond positive or negative noise threshold starts compensation.
// - compensation also starts at configurable periodic intervals.
// - host may request compensation, e.g. after sensitivity change; device performs it.
// - raw counts are low-pass filtered into a per-input average.
// - deviation is raw count minus its average.
// - status and level control derive from deviation, average and shadow store.
// - without host programming start with a built-in eight-button default configuration.
// - the default configuration table is read-only.
// - at power-up use valid nonvolatile data else default table, copy into shadow store.
// - compensation completion asserts the active-low interrupt, possibly one scan late.
// - level output pulse generator supports period 256 (default) or 64.
`ifndef TRC_DEFS_VH
`define TRC_DEFS_VH
`define TRC_NIN 8
`define TRC_CNT_W 16
`define TRC_PWM_LONG 8'hFF
`define TRC_PWM_SHORT 8'h3F
`define TRC_AVG_SHIFT 3
`define TRC_SRC_NVM 1'b1
`define TRC_SRC_DEF 1'b0
`define TRC_BUZ_GND 2'h0
`define TRC_BUZ_VDD 2'h1
`define TRC_BUZ_IDLE 2'h2
`define TRC_DEF_ENABLE 8'hFF
`define TRC_DEF_SENS 3'h4
`define TRC_DEF_TOUCH_TH 16'h0040
`define TRC_DEF_IDLE 8'h00
`define TRC_DEF_PERIODIC 8'h00
`endif

// File: trc_pwm.v
// level output pulse-width generator, 256 or 64 step period
`timescale 1ns/1ps
module trc_pwm (
  input wire clk, // system clock
  input wire rst_b, // async reset, active low
  input wire step, // one-cycle step enable
  input wire short_period, // 1 selects 64 steps
  input wire [7:0] width, // high steps per period
  output reg pwm // pulse output
);
`include "trc_defs.vh"
  reg [7:0] phase;
  wire [7:0] last = short_period ? `TRC_PWM_SHORT : `TRC_PWM_LONG;
  // free-running phase, wraps at the chosen period
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 8'h00;
      pwm <= 1'b0;
    end else if (step) begin
      phase <= (phase >= last) ? 8'h00 : phase + 8'h01;
      pwm <= (phase < width);
    end
  end
endmodule

// File: trc_chan.v
// per-input average, deviation and compensation search
`timescale 1ns/1ps
module trc_chan (
  input wire clk, // system clock
  input wire rst_b, // async reset, active low
  input wire sample, // new raw count valid
  input wire [15:0] raw, // raw count from front end
  input wire comp_go, // start compensation search
  input wire [15:0] pos_th, // positive noise threshold
  input wire [15:0] neg_th, // negative noise threshold (magnitude)
  output reg [15:0] comp_val, // compensation value
  output reg comp_busy, // search running
  output reg [15:0] avg, // filtered count
  output wire signed [16:0] dev, // raw minus average
  output wire drift // average beyond a threshold
);
`include "trc_defs.vh"
  reg [3:0] bitpos;
  reg [15:0] raw_q;
  wire signed [16:0] sraw = {1'b0, raw};
  wire signed [16:0] savg = {1'b0, avg};
  wire signed [16:0] sraw_q = {1'b0, raw_q};
  wire signed [16:0] dev_in = sraw - savg;
  wire signed [16:0] dev_step = dev_in >>> `TRC_AVG_SHIFT;
  // deviation of this input's own last count, not of whatever is on the shared bus
  assign dev = sraw_q - savg;
  // count sits around zero when compensated; plain unsigned compare on the positive side, magnitude compare on the negative side
  assign drift = !comp_busy && ((avg > pos_th) || (avg[15] && ((~avg + 16'h0001) > neg_th)));
  // successive approximation: keep a bit if the count stays non-negative
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      comp_val <= 16'h0000;
      comp_busy <= 1'b0;
      bitpos <= 4'hF;
      avg <= 16'h0000;
      raw_q <= 16'h0000;
    end else if (comp_go && !comp_busy) begin
      comp_busy <= 1'b1;
      bitpos <= 4'hF;
      comp_val <= 16'h8000;
      avg <= 16'h0000;
      raw_q <= 16'h0000;
    end else if (sample && comp_busy) begin
      // raw is offset-corrected count; overshoot shows as a wrapped top bit
      if (raw[15])
        comp_val[bitpos] <= 1'b0;
      if (bitpos == 4'h0)
        comp_busy <= 1'b0;
      else begin
        bitpos <= bitpos - 4'h1;
        comp_val[bitpos - 4'h1] <= 1'b1;
      end
    end else if (sample) begin
      // first-order low-pass: avg += (raw - avg) / 8
      avg <= avg + dev_step[15:0];
      raw_q <= raw;
    end
  end
endmodule

// File: trc_top.v
// touch scan, compensation control and strongest-button reporting
`timescale 1ns/1ps
module trc_top (
  input wire CLK_SYS, // 125 MHz system clock
  input wire RST_B, // async reset, active low
  input wire SCAN_TICK, // one-cycle start of a sensing period
  input wire PWM_STEP, // one-cycle pulse generator step
  input wire NVM_VALID, // nonvolatile store holds valid data
  input wire [7:0] NVM_ENABLE, // nonvolatile input enables
  input wire [23:0] NVM_SENS, // nonvolatile 3-bit sensitivity per input
  input wire [15:0] NVM_TOUCH_TH, // nonvolatile touch threshold
  input wire [7:0] NVM_IDLE, // nonvolatile idle level
  input wire [7:0] NVM_PERIODIC, // nonvolatile periodic compensation scans, 0 off
  input wire [15:0] POS_TH, // positive noise threshold
  input wire [15:0] NEG_TH, // negative noise threshold
  input wire [63:0] BUTTON_LEVEL, // pulse width per button
  input wire HOST_COMP_REQ, // one-cycle host compensation request
  input wire HOST_READ, // one-cycle host status read, clears interrupt
  input wire BUZZER_ON, // buzzer active level
  input wire [1:0] BUZ_MODE, // output while buzzer active
  input wire IDLE_AFTER_BUZ, // idle one scan after buzzer
  input wire IDLE_ON_SWITCH, // idle one scan on takeover
  input wire SHORT_PERIOD, // 64-step pulse period
  input wire SLEEP, // sleep operation
  output reg FE_START, // one-cycle start of one measurement
  output reg [2:0] FE_SEL, // selected input
  output reg [7:0] FE_CYCLES, // accumulation cycles
  output reg [15:0] FE_COMP, // compensation value applied
  output reg FE_POWER, // front end powered
  input wire FE_DONE, // one-cycle measurement done
  input wire [15:0] FE_COUNT, // compensated raw count
  output reg [7:0] BUTTON_STATUS, // reported button, one-hot
  output reg LEVEL_OUT, // analog level output pulse
  output reg INT_B, // interrupt, active low
  output reg CFG_SRC, // 1 nonvolatile, 0 default
  output reg [15:0] COUNT_OUT // count of last measured input
);
`include "trc_defs.vh"
  localparam S_IDLE = 3'b001;
  localparam S_MEAS = 3'b010;
  localparam S_WAIT = 3'b100;
  reg [2:0] state;
  reg [2:0] idx;
  reg [7:0] en;
  reg [23:0] sens;
  reg [15:0] touch_th;
  reg [7:0] idle_lvl;
  reg [7:0] periodic;
  reg [7:0] per_cnt;
  reg loaded;
  reg power_comp;
  reg [7:0] comp_go;
  reg [7:0] sample;
  reg scan_end;
  reg report_tick;
  reg [7:0] was_busy;
  reg reported_v;
  reg [2:0] reported;
  reg idle_hold;
  reg buz_d;
  reg [7:0] width;
  reg [7:0] touched;
  wire [7:0] busy;
  wire [7:0] drift;
  wire [127:0] comp_bus;
  wire [135:0] dev_bus;
  wire pwm;
  // shadow store copy at power-up: valid nonvolatile data or the fixed default table
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      loaded <= 1'b0;
      en <= `TRC_DEF_ENABLE;
      sens <= {8{`TRC_DEF_SENS}};
      touch_th <= `TRC_DEF_TOUCH_TH;
      idle_lvl <= `TRC_DEF_IDLE;
      periodic <= `TRC_DEF_PERIODIC;
      CFG_SRC <= `TRC_SRC_DEF;
    end else if (!loaded) begin
      loaded <= 1'b1;
      if (NVM_VALID) begin
        en <= NVM_ENABLE;
        sens <= NVM_SENS;
        touch_th <= NVM_TOUCH_TH;
        idle_lvl <= NVM_IDLE;
        periodic <= NVM_PERIODIC;
        CFG_SRC <= `TRC_SRC_NVM;
      end
      // default table is constants only; no port writes it
    end
  end
  // scan sequencer over enabled inputs
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state <= S_IDLE;
      idx <= 3'h0;
      FE_START <= 1'b0;
      FE_SEL <= 3'h0;
      FE_CYCLES <= 8'h00;
      FE_COMP <= 16'h0000;
      FE_POWER <= 1'b0;
      sample <= 8'h00;
      scan_end <= 1'b0;
      COUNT_OUT <= 16'h0000;
    end else begin
      FE_START <= 1'b0;
      sample <= 8'h00;
      scan_end <= 1'b0;
      case (state)
        S_IDLE: begin
          if (SCAN_TICK && loaded && !SLEEP) begin
            if (en == 8'h00)
              scan_end <= 1'b1;
            else begin
              idx <= 3'h0;
              FE_POWER <= 1'b1;
              state <= S_MEAS;
            end
          end
        end
        S_MEAS: begin
          if (en[idx]) begin
            FE_SEL <= idx;
            FE_CYCLES <= 8'h01 << sens[idx*3 +: 3];
            FE_COMP <= comp_bus[idx*16 +: 16];
            FE_START <= 1'b1;
            state <= S_WAIT;
          end else if (idx == 3'h7) begin
            FE_POWER <= 1'b0;
            scan_end <= 1'b1;
            state <= S_IDLE;
          end else
            idx <= idx + 3'h1;
        end
        S_WAIT: begin
          if (FE_DONE) begin
            sample[idx] <= 1'b1;
            COUNT_OUT <= FE_COUNT;
            if (idx == 3'h7) begin
              FE_POWER <= 1'b0;
              scan_end <= 1'b1;
              state <= S_IDLE;
            end else begin
              idx <= idx + 3'h1;
              state <= S_MEAS;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : ch
      trc_chan u_chan (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .sample(sample[g]),
        .raw(COUNT_OUT), // held copy; the bus count is only valid with done
        .comp_go(comp_go[g]),
        .pos_th(POS_TH),
        .neg_th(NEG_TH),
        .comp_val(comp_bus[g*16 +: 16]),
        .comp_busy(busy[g]),
        .avg(),
        .dev(dev_bus[g*17 +: 17]),
        .drift(drift[g])
      );
    end
  endgenerate
  // compensation triggers; a host request starts compensation at once, without waiting for a scan boundary
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      power_comp <= 1'b1;
      comp_go <= 8'h00;
      per_cnt <= 8'h00;
      was_busy <= 8'h00;
      INT_B <= 1'b0;
    end else begin
      comp_go <= 8'h00;
      was_busy <= busy;
      if (scan_end) begin
        if (periodic != 8'h00)
          per_cnt <= (per_cnt + 8'h01 >= periodic) ? 8'h00 : per_cnt + 8'h01;
        if (power_comp || HOST_COMP_REQ || (periodic != 8'h00 && per_cnt + 8'h01 >= periodic))
          comp_go <= en;
        else
          comp_go <= drift & en;
        power_comp <= 1'b0;
      end else if (HOST_COMP_REQ) begin
        comp_go <= en;
      end
      // completion sets the interrupt; set beats a same-cycle read
      if ((was_busy & ~busy) != 8'h00 && busy == 8'h00)
        INT_B <= 1'b0;
      else if (HOST_READ || (loaded && !power_comp && busy == 8'h00 && INT_B == 1'b0 && HOST_READ))
        INT_B <= 1'b1;
    end
  end
  // touch detection, strongest with lower index winning ties
  integer i;
  reg [2:0] best;
  reg best_v;
  reg [16:0] best_dev;
  reg [7:0] cur_touched;
  always @* begin
    best = 3'h0;
    best_v = 1'b0;
    best_dev = 17'h00000;
    cur_touched = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      if (en[i] && !busy[i] && !dev_bus[i*17+16] && dev_bus[i*17 +: 16] >= touch_th) begin
        cur_touched[i] = 1'b1;
        if (!best_v || dev_bus[i*17 +: 17] > best_dev) begin
          best = i[2:0];
          best_v = 1'b1;
          best_dev = dev_bus[i*17 +: 17];
        end
      end
    end
  end
  // report one cycle after scan end so the last input's average has settled
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B)
      report_tick <= 1'b0;
    else
      report_tick <= scan_end;
  end
  // reporting update once per scan
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      reported_v <= 1'b0;
      reported <= 3'h0;
      idle_hold <= 1'b0;
      BUTTON_STATUS <= 8'h00;
      touched <= 8'h00;
    end else if (report_tick) begin
      touched <= cur_touched;
      idle_hold <= 1'b0;
      if (!best_v) begin
        reported_v <= 1'b0;
        BUTTON_STATUS <= 8'h00;
      end else if (!reported_v || !cur_touched[reported]
                   || dev_bus[best*17 +: 17] > dev_bus[reported*17 +: 17]) begin
        if (reported_v && reported != best && IDLE_ON_SWITCH)
          idle_hold <= 1'b1;
        reported_v <= 1'b1;
        reported <= best;
        BUTTON_STATUS <= 8'h01 << best;
      end
      // weaker release keeps the current report
    end
  end
  // level selection with buzzer and sleep overrides
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      buz_d <= 1'b0;
      width <= 8'h00;
      LEVEL_OUT <= 1'b0;
    end else begin
      // marker outlives the buzzer until a scan boundary when idle is wanted
      buz_d <= BUZZER_ON || (buz_d && IDLE_AFTER_BUZ && !scan_end);
      width <= (idle_hold || buz_d || !reported_v) ? idle_lvl : BUTTON_LEVEL[reported*8 +: 8];
      if (SLEEP)
        LEVEL_OUT <= 1'b0;
      else if (BUZZER_ON) begin
        case (BUZ_MODE)
          `TRC_BUZ_GND: LEVEL_OUT <= 1'b0;
          `TRC_BUZ_VDD: LEVEL_OUT <= 1'b1;
          default: LEVEL_OUT <= pwm;
        endcase
      end else
        LEVEL_OUT <= pwm;
    end
  end
  trc_pwm u_pwm (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .step(PWM_STEP),
    .short_period(SHORT_PERIOD),
    .width(width),
    .pwm(pwm)
  );
endmodule

// File: trc_top_props.sv
// assertion checker on the touch report block ports
`timescale 1ns/1ps
module trc_top_props (
  input wire CLK_SYS, // system clock
  input wire RST_B, // async reset, active low
  input wire SCAN_TICK, // sensing period start
  input wire NVM_VALID, // nonvolatile data valid
  input wire [7:0] NVM_ENABLE, // nonvolatile enables
  input wire [23:0] NVM_SENS, // nonvolatile sensitivity
  input wire HOST_READ, // host status read
  input wire BUZZER_ON, // buzzer active
  input wire [1:0] BUZ_MODE, // output while buzzer active
  input wire SLEEP, // sleep operation
  input wire FE_START, // measurement start
  input wire [2:0] FE_SEL, // selected input
  input wire [7:0] FE_CYCLES, // accumulation cycles
  input wire FE_POWER, // front end powered
  input wire [7:0] BUTTON_STATUS, // reported button
  input wire LEVEL_OUT, // level output
  input wire INT_B // interrupt, active low
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // never more than one reported button
  a_status_one_hot: assert property ($onehot0(BUTTON_STATUS))
    else $error("more than one button reported");
  // two cycles of slack; the override reaches the level output through the output flop only
  a_sleep_ground: assert property (SLEEP [*3] |-> !LEVEL_OUT)
    else $error("level output high in sleep");
  a_buzz_ground: assert property ((BUZZER_ON && BUZ_MODE == 2'h0) [*3] |-> !LEVEL_OUT)
    else $error("level output not grounded under buzzer");
  a_buzz_supply: assert property ((BUZZER_ON && BUZ_MODE == 2'h1 && !SLEEP) [*3] |-> LEVEL_OUT)
    else $error("level output not at supply under buzzer");
  a_start_powered: assert property (FE_START |-> FE_POWER)
    else $error("measurement started with front end off");
  a_start_single: assert property (FE_START |=> !FE_START)
    else $error("measurement start longer than one cycle");
  a_skip_disabled: assert property (FE_START |-> (!NVM_VALID || NVM_ENABLE[FE_SEL]))
    else $error("disabled input measured");
  a_cycles_sens: assert property (FE_START |-> FE_CYCLES == (8'h01 << (NVM_VALID ? NVM_SENS[FE_SEL*3 +: 3] : 3'h4)))
    else $error("accumulation cycles differ from sensitivity");
  a_power_cause: assert property ($rose(FE_POWER) |-> $past(SCAN_TICK) || $past(SCAN_TICK, 2))
    else $error("front end powered outside a sensing period");
  a_int_clear: assert property ($rose(INT_B) |-> $past(HOST_READ))
    else $error("interrupt released without host read");
endmodule
bind trc_top trc_top_props i_props (.CLK_SYS, .RST_B, .SCAN_TICK, .NVM_VALID, .NVM_ENABLE, .NVM_SENS,
  .HOST_READ, .BUZZER_ON, .BUZ_MODE, .SLEEP, .FE_START, .FE_SEL, .FE_CYCLES, .FE_POWER,
  .BUTTON_STATUS, .LEVEL_OUT, .INT_B);

// File: trc_fe_model.sv
// behavioural charge sensing front end with offset subtraction
`timescale 1ns/1ps
module trc_fe_model (
  input wire clk, // system clock
  input wire rst_b, // async reset, active low
  input wire fe_start, // measurement start
  input wire [2:0] fe_sel, // selected input
  input wire [15:0] fe_comp, // compensation applied
  input wire [127:0] cap, // untouched level per input
  input wire [127:0] touch, // finger signal per input
  output reg fe_done, // measurement done
  output reg [15:0] fe_count // compensated count
);
  reg busy;
  reg [3:0] wait_cnt;
  reg [2:0] sel;
  reg [15:0] comp;
  // higher inputs answer slower, so both prompt and late answers occur
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      fe_done <= 1'b0;
      fe_count <= 16'hFFFF;
      wait_cnt <= 4'h0;
      sel <= 3'h0;
      comp <= 16'h0000;
    end else begin
      fe_done <= 1'b0;
      fe_count <= ~fe_count; // count is not held once done has passed
      if (fe_start) begin
        busy <= 1'b1;
        sel <= fe_sel;
        comp <= fe_comp;
        wait_cnt <= {1'b0, fe_sel} + 4'h1;
      end else if (busy && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        fe_done <= 1'b1;
        fe_count <= cap[sel*16 +: 16] + touch[sel*16 +: 16] - comp;
      end
    end
  end
endmodule

// File: tb_trc_top.sv
// self-checking bench for the touch report block
`timescale 1ns/1ps
module tb_trc_top;
  reg CLK_SYS, RST_B, SCAN_TICK, PWM_STEP, NVM_VALID, HOST_COMP_REQ, HOST_READ, BUZZER_ON;
  reg IDLE_AFTER_BUZ, IDLE_ON_SWITCH, SHORT_PERIOD, SLEEP;
  reg [7:0] NVM_ENABLE, NVM_IDLE, NVM_PERIODIC;
  reg [23:0] NVM_SENS;
  reg [15:0] NVM_TOUCH_TH, POS_TH, NEG_TH;
  reg [63:0] BUTTON_LEVEL;
  reg [1:0] BUZ_MODE;
  reg [127:0] cap, touch;
  wire FE_START, FE_POWER, FE_DONE, LEVEL_OUT, INT_B, CFG_SRC;
  wire [2:0] FE_SEL;
  wire [7:0] FE_CYCLES, BUTTON_STATUS;
  wire [15:0] FE_COMP, FE_COUNT, COUNT_OUT;
  reg [15:0] seen_comp [0:7];
  integer err_total, total_checks, n_start, i;
  trc_top i_dut (.CLK_SYS, .RST_B, .SCAN_TICK, .PWM_STEP, .NVM_VALID, .NVM_ENABLE, .NVM_SENS,
    .NVM_TOUCH_TH, .NVM_IDLE, .NVM_PERIODIC, .POS_TH, .NEG_TH, .BUTTON_LEVEL, .HOST_COMP_REQ,
    .HOST_READ, .BUZZER_ON, .BUZ_MODE, .IDLE_AFTER_BUZ, .IDLE_ON_SWITCH, .SHORT_PERIOD, .SLEEP,
    .FE_START, .FE_SEL, .FE_CYCLES, .FE_COMP, .FE_POWER, .FE_DONE, .FE_COUNT, .BUTTON_STATUS,
    .LEVEL_OUT, .INT_B, .CFG_SRC, .COUNT_OUT);
  trc_fe_model i_fe (.clk(CLK_SYS), .rst_b(RST_B), .fe_start(FE_START), .fe_sel(FE_SEL),
    .fe_comp(FE_COMP), .cap(cap), .touch(touch), .fe_done(FE_DONE), .fe_count(FE_COUNT));
  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end
  // record applied offsets and count measurements
  always @(posedge CLK_SYS) begin
    if (FE_START === 1'b1) begin
      seen_comp[FE_SEL] <= FE_COMP;
      n_start <= n_start + 1;
    end
  end
  task check(input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // one sensing period; bounded wait for the front end to power down
  task scan;
    integer k;
    begin
      @(posedge CLK_SYS) SCAN_TICK <= 1'b1;
      @(posedge CLK_SYS) SCAN_TICK <= 1'b0;
      repeat (3) @(posedge CLK_SYS);
      k = 0;
      while (FE_POWER === 1'b1 && k < 300) begin
        @(posedge CLK_SYS);
        k = k + 1;
      end
      if (k >= 300) err_total = err_total + 1;
      repeat (3) @(posedge CLK_SYS);
      #1;
    end
  endtask
  // high steps over one period, after a full period to settle
  task count_hi(input integer n, input [15:0] exp);
    integer k;
    reg [15:0] hi;
    begin
      repeat (256) @(posedge CLK_SYS);
      hi = 16'h0000;
      for (k = 0; k < n; k = k + 1) begin
        @(posedge CLK_SYS);
        #1;
        if (LEVEL_OUT === 1'b1) hi = hi + 16'h0001;
      end
      check(hi, exp);
    end
  endtask
  task host_read;
    begin
      @(posedge CLK_SYS) HOST_READ <= 1'b1;
      @(posedge CLK_SYS) HOST_READ <= 1'b0;
      @(posedge CLK_SYS);
      #1;
    end
  endtask
  initial begin
    repeat (60000) @(posedge CLK_SYS);
    err_total = err_total + 1;
    end_of_test;
  end
  initial begin
    err_total = 0;
    total_checks = 0;
    n_start = 0;
    RST_B = 1'b0;
    {SCAN_TICK, HOST_COMP_REQ, HOST_READ, BUZZER_ON, SLEEP, SHORT_PERIOD} = 6'h00;
    {IDLE_AFTER_BUZ, IDLE_ON_SWITCH, NVM_VALID, PWM_STEP} = 4'h1;
    {NVM_ENABLE, NVM_IDLE, NVM_PERIODIC, NVM_SENS} = 48'h0;
    {NVM_TOUCH_TH, POS_TH, NEG_TH} = {16'h0040, 16'h4000, 16'h4000};
    BUZ_MODE = 2'h0;
    BUTTON_LEVEL = 64'h7060504030208040;
    touch = 128'h0;
    for (i = 0; i < 8; i = i + 1) cap[i*16 +: 16] = 16'h1000 + i * 16'h0111;
    repeat (5) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    #1 check(CFG_SRC, 16'h0000);
    host_read;
    scan;
    check(n_start, 16'h0008);
    repeat (19) scan;
    check(INT_B, 16'h0000);
    repeat (30) scan;
    for (i = 0; i < 8; i = i + 1) check(seen_comp[i], cap[i*16 +: 16]);
    check(COUNT_OUT, 16'h0000);
    touch[15:0] = 16'h0080;
    scan;
    check(BUTTON_STATUS, 16'h0001);
    count_hi(256, 16'h0040);
    touch[31:16] = 16'h0100;
    scan;
    check(BUTTON_STATUS, 16'h0002);
    count_hi(256, 16'h0080);
    touch[47:32] = 16'h0050;
    scan;
    check(BUTTON_STATUS, 16'h0002);
    touch[15:0] = 16'h0000;
    scan;
    check(BUTTON_STATUS, 16'h0002);
    touch = 128'h0;
    scan;
    check(BUTTON_STATUS, 16'h0000);
    count_hi(256, 16'h0000);
    touch[79:48] = 32'h00900090;
    scan;
    check(BUTTON_STATUS, 16'h0008);
    @(posedge CLK_SYS) BUZZER_ON <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge CLK_SYS) BUZ_MODE <= i[1:0];
      count_hi(256, (i == 1) ? 16'h0100 : 16'h0000);
    end
    @(posedge CLK_SYS) BUZZER_ON <= 1'b0;
    count_hi(256, 16'h0030);
    @(posedge CLK_SYS) SHORT_PERIOD <= 1'b1;
    count_hi(64, 16'h0030);
    @(posedge CLK_SYS) SLEEP <= 1'b1;
    count_hi(256, 16'h0000);
    n_start = 0;
    scan;
    check(n_start, 16'h0000);
    @(posedge CLK_SYS) SLEEP <= 1'b0;
    SHORT_PERIOD <= 1'b0;
    touch = 128'h0;
    cap[15:0] = 16'h1123;
    host_read;
    @(posedge CLK_SYS) HOST_COMP_REQ <= 1'b1;
    @(posedge CLK_SYS) HOST_COMP_REQ <= 1'b0;
    repeat (19) scan;
    check(INT_B, 16'h0000);
    scan;
    check(seen_comp[0], 16'h1123);
    // second reset, now with valid nonvolatile data and two inputs disabled
    @(posedge CLK_SYS) RST_B <= 1'b0;
    {NVM_VALID, NVM_ENABLE, NVM_SENS, NVM_IDLE, NVM_PERIODIC} <= {1'b1, 8'h5F, 24'hFAC688, 8'h20, 8'h02};
    {IDLE_AFTER_BUZ, IDLE_ON_SWITCH} <= 2'h3;
    repeat (5) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    #1 check(CFG_SRC, 16'h0001);
    n_start = 0;
    scan;
    check(n_start, 16'h0006);
    check(seen_comp[0], 16'h0000);
    repeat (19) scan;
    host_read;
    repeat (20) scan;
    check(INT_B, 16'h0000);
    count_hi(256, 16'h0020);
    end_of_test;
  end
endmodule
